// File: src/simd_ctl_pkg.sv
// Constants and types shared by the multimedia alias and prefix control block
package simd_ctl_pkg;

  // ==================================================
  // Tag word and register file shape
  localparam int NUM_REGS = 8;
  localparam int TAG_W = 2;
  localparam int REG_W = 80;
  localparam int EXP_LO = 64;
  localparam int EXP_HI = 79;
  localparam logic [1:0] TAG_VALID = 2'h0;
  localparam logic [1:0] TAG_EMPTY = 2'h3;
  localparam logic [1:0] TAG_RESET = 2'h3;
  localparam logic [15:0] EXP_ONES = 16'hFFFF;
  localparam logic [2:0] TOP_CLEAR = 3'h0;
  localparam logic [2:0] TOP_RESET = 3'h0;

  // ==================================================
  // Exception vectors
  localparam logic [7:0] VEC_INVALID_OP = 8'h06;
  localparam logic [7:0] VEC_SEG_NP = 8'h0B;
  localparam logic [7:0] VEC_STACK = 8'h0C;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [7:0] VEC_PAGE = 8'h0E;
  localparam logic [7:0] VEC_NUMERIC = 8'h10;

  // ==================================================
  // Prefix byte codes
  localparam logic [7:0] PFX_ADDR = 8'h67;
  localparam logic [7:0] PFX_OPSZ = 8'h66;
  localparam logic [7:0] PFX_CS = 8'h2E;
  localparam logic [7:0] PFX_SS = 8'h36;
  localparam logic [7:0] PFX_DS = 8'h3E;
  localparam logic [7:0] PFX_ES = 8'h26;
  localparam logic [7:0] PFX_FS = 8'h64;
  localparam logic [7:0] PFX_GS = 8'h65;
  localparam logic [7:0] PFX_REP = 8'hF3;
  localparam logic [7:0] PFX_REPNE = 8'hF2;
  localparam logic [7:0] PFX_LOCK = 8'hF0;

  // Prefix summary bit positions
  localparam int PB_ADDR = 0;
  localparam int PB_SEG = 1;
  localparam int PB_OPSZ = 2;
  localparam int PB_REP = 3;
  localparam int PB_LOCK = 4;
  localparam int PB_W = 5;

  // Memory fault kinds reported by the address unit
  typedef enum logic [2:0] {
    MF_NONE = 3'b000,
    MF_PAGE = 3'b001,
    MF_SEGNP = 3'b010,
    MF_LIMIT = 3'b011,
    MF_STACK = 3'b100
  } mem_fault_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RETRY = 2'b10
  } ctl_state_e;

endpackage : simd_ctl_pkg

// File: src/simd_prefix_check.sv
// Prefix classifier for multimedia instructions
`timescale 1ns/10ps
module simd_prefix_check
(
  input wire logic [7:0] pfxByte, // Prefix byte
  input wire logic pfxValid, // Byte is a real prefix
  output logic [simd_ctl_pkg::PB_W-1:0] pfxBits // One-hot class of the byte
);
  import simd_ctl_pkg::*;

  always_comb begin
    pfxBits = '0;
    if (!pfxValid) begin
      pfxBits = '0;
    end else if (pfxByte == PFX_ADDR) begin
      pfxBits[PB_ADDR] = 1'b1;
    end else if (pfxByte == PFX_CS || pfxByte == PFX_SS ||
                 pfxByte == PFX_DS || pfxByte == PFX_ES ||
                 pfxByte == PFX_FS || pfxByte == PFX_GS) begin
      pfxBits[PB_SEG] = 1'b1;
    end else if (pfxByte == PFX_OPSZ) begin
      pfxBits[PB_OPSZ] = 1'b1;
    end else if (pfxByte == PFX_REP || pfxByte == PFX_REPNE) begin
      pfxBits[PB_REP] = 1'b1;
    end else if (pfxByte == PFX_LOCK) begin
      pfxBits[PB_LOCK] = 1'b1;
    end
  end

endmodule : simd_prefix_check

// File: src/simd_fpu_alias_ctl.sv
// Multimedia instruction control on the shared floating-point state
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module simd_fpu_alias_ctl
(
  input wire logic sys_clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic instrValid, // Multimedia instruction issued
  input wire logic isEmptyInstr, // Issued op is empty_simd_state_instr
  input wire logic instrSupported, // Opcode implemented
  input wire logic hasMemOperand, // Instruction has a memory operand
  input wire logic writesReg, // Instruction writes a register
  input wire logic [2:0] destReg, // Destination register number
  input wire logic [63:0] resultData, // Result to write
  input wire logic [2:0] srcReg, // Register read port select
  input wire logic [7:0] pfxByte, // Prefix byte
  input wire logic pfxValid, // Prefix byte present this cycle
  input wire logic fpuEmulationBit, // fpu_emulation_bit control
  input wire logic strictReserved, // Fault on reserved prefixes
  input wire logic fpuPending, // Unmasked float exception pending
  input wire logic handlerReturn, // Numeric handler has returned
  input wire logic [2:0] memFault, // Fault kind from address unit
  input wire logic [1:0] segSelIn, // Default segment for memory forms
  input wire logic [1:0] segOvr, // Segment from override prefix
  input wire logic addrSizeIn, // Default address size
  output logic [15:0] tagWord, // Shared tag word
  output logic [2:0] stackTopField, // stack_top_field of status word
  output logic [simd_ctl_pkg::REG_W-1:0] regRead, // Shared register read data
  output logic instrDone, // Instruction retired, pulse
  output logic faultValid, // Fault raised, pulse
  output logic [7:0] faultVector, // Vector of the fault
  output logic invalidOpcodeFault, // invalid_opcode_fault, pulse
  output logic floatErrorOut, // float_error_out level
  output logic [1:0] effSegment, // Segment used for the access
  output logic effAddrSize, // Address size used for the access
  output logic irq // Interrupt, level
);
  import simd_ctl_pkg::*;

  // ==================================================
  // Prefix accumulation
  logic [PB_W-1:0] pfxBits;
  logic [PB_W-1:0] pfxSeen_reg;
  logic segSeen_reg;
  logic [1:0] segOvr_reg;

  simd_prefix_check u_simd_prefix_check (
    .pfxByte(pfxByte),
    .pfxValid(pfxValid),
    .pfxBits(pfxBits)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pfxSeen_reg <= '0;
      segOvr_reg <= 2'h0;
      segSeen_reg <= 1'b0;
    end else if (instrValid) begin
      pfxSeen_reg <= '0;
      segSeen_reg <= 1'b0;
    end else begin
      pfxSeen_reg <= pfxSeen_reg | pfxBits;
      if (pfxBits[PB_SEG]) begin
        segSeen_reg <= 1'b1;
        segOvr_reg <= segOvr;
      end
    end
  end

  // ==================================================
  // Decision
  function automatic logic [7:0] memVec(input logic [2:0] k);
    if (k == MF_PAGE) memVec = VEC_PAGE;
    else if (k == MF_SEGNP) memVec = VEC_SEG_NP;
    else if (k == MF_STACK) memVec = VEC_STACK;
    else memVec = VEC_GP;
  endfunction : memVec

  ctl_state_e state_reg;
  logic reservedPfx;
  logic badOpHit;
  logic memHit;
  logic numHit;
  logic execOk;

  always_comb begin
    reservedPfx = pfxSeen_reg[PB_OPSZ] | pfxSeen_reg[PB_REP];
    if (!hasMemOperand) begin
      reservedPfx = reservedPfx | pfxSeen_reg[PB_ADDR]
                    | segSeen_reg;
    end
    badOpHit = instrValid && (!instrSupported || fpuEmulationBit
               || pfxSeen_reg[PB_LOCK]
               || (strictReserved && reservedPfx));
    numHit = instrValid && !badOpHit && fpuPending;
    memHit = instrValid && !badOpHit && !numHit && hasMemOperand
             && memFault != MF_NONE;
    execOk = instrValid && !badOpHit && !numHit && !memHit;
  end

  // ==================================================
  // Pending exception sequencing
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (numHit) state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (handlerReturn) state_reg <= ST_RETRY;
        end
        ST_RETRY: begin
          if (execOk) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      floatErrorOut <= 1'b0;
    end else if (numHit) begin
      floatErrorOut <= 1'b1;
    end else if (handlerReturn) begin
      floatErrorOut <= 1'b0;
    end
  end

  // ==================================================
  // Fault reporting
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      faultValid <= 1'b0;
      faultVector <= 8'h00;
      invalidOpcodeFault <= 1'b0;
      instrDone <= 1'b0;
      effSegment <= 2'h0;
      effAddrSize <= 1'b0;
    end else begin
      faultValid <= badOpHit | numHit | memHit;
      invalidOpcodeFault <= badOpHit;
      instrDone <= execOk;
      if (badOpHit) faultVector <= VEC_INVALID_OP;
      else if (numHit) faultVector <= VEC_NUMERIC;
      else if (memHit) faultVector <= memVec(memFault);
      if (instrValid && hasMemOperand) begin
        effSegment <= segSeen_reg ? segOvr_reg : segSelIn;
        effAddrSize <= addrSizeIn ^ pfxSeen_reg[PB_ADDR];
      end
    end
  end

  // ==================================================
  // Shared register file and tags
  logic [REG_W-1:0] fpRegs [NUM_REGS];

  always_ff @(posedge sys_clk) begin
    if (execOk && !isEmptyInstr && writesReg) begin
      fpRegs[destReg] <= {EXP_ONES, resultData};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRead <= '0;
    end else begin
      regRead <= fpRegs[srcReg];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tagWord <= {NUM_REGS{TAG_RESET}};
      stackTopField <= TOP_RESET;
    end else if (execOk && isEmptyInstr) begin
      tagWord <= {NUM_REGS{TAG_EMPTY}};
    end else if (execOk) begin
      tagWord <= {NUM_REGS{TAG_VALID}};
      stackTopField <= TOP_CLEAR;
    end
  end

  // ==================================================
  // Interrupt
  assign irq = floatErrorOut;

  // ==================================================
  // Checks
  a_tag_valid: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    execOk && !isEmptyInstr |=> tagWord == 16'h0000)
    else $error("tag word not valid after instruction");
  a_tag_empty: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    execOk && isEmptyInstr |=> tagWord == 16'hFFFF)
    else $error("tag word not empty after empty-state op");
  a_empty_code: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    execOk && isEmptyInstr |=> tagWord[1:0] == 2'h3)
    else $error("empty tag code wrong");
  a_top_clear: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    execOk && !isEmptyInstr |=> stackTopField == 3'h0)
    else $error("stack top not cleared");
  a_fault_keeps_tag: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && !execOk |=> $stable(tagWord))
    else $error("faulted instruction changed the tag word");
  a_exp_ones: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    execOk && !isEmptyInstr && writesReg ##1 srcReg == $past(destReg)
    |=> regRead[79:64] == 16'hFFFF)
    else $error("exponent bits not all ones");
  a_emul_fault: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && fpuEmulationBit |=> invalidOpcodeFault
    && faultVector == 8'h06)
    else $error("emulation bit did not fault");
  a_unsup_fault: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && !instrSupported |=> invalidOpcodeFault
    && faultVector == 8'h06 && !instrDone)
    else $error("unsupported opcode did not fault");
  a_mem_page: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    memHit && memFault == MF_PAGE |=> faultVector == 8'h0E)
    else $error("page fault vector wrong");
  a_mem_segnp: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    memHit && memFault == MF_SEGNP |=> faultVector == 8'h0B)
    else $error("segment not present vector wrong");
  a_mem_limit: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    memHit && memFault == MF_LIMIT |=> faultVector == 8'h0D)
    else $error("limit violation vector wrong");
  a_mem_stack: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    memHit && memFault == MF_STACK |=> faultVector == 8'h0C)
    else $error("stack fault vector wrong");
  a_no_numeric: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    faultValid && faultVector == 8'h10 |-> $past(fpuPending))
    else $error("numeric fault without pending exception");
  a_num_pending: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && !fpuPending |=> !(faultValid && faultVector == 8'h10))
    else $error("numeric fault raised with nothing pending");
  a_num_vec: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    numHit |=> faultVector == 8'h10 && floatErrorOut)
    else $error("pending exception not reported");
  a_num_first: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    numHit |=> faultValid && !instrDone && !invalidOpcodeFault)
    else $error("pending exception not reported as a fault");
  a_err_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    floatErrorOut && !handlerReturn |=> floatErrorOut)
    else $error("error output dropped before handler return");
  a_err_clear: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    handlerReturn && !numHit |=> !floatErrorOut)
    else $error("error output held after handler return");
  a_retry_wait: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    state_reg == ST_WAIT && handlerReturn |=> state_reg == ST_RETRY)
    else $error("no retry after handler");
  a_wait_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    state_reg == ST_WAIT && !handlerReturn |=> state_reg == ST_WAIT)
    else $error("pending wait left without handler return");
  a_retry_done: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    state_reg == ST_RETRY && execOk |=> instrDone
    && state_reg == ST_IDLE)
    else $error("retried instruction did not complete");
  a_addr_size: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && hasMemOperand |=> effAddrSize
    == ($past(addrSizeIn) ^ $past(pfxSeen_reg[PB_ADDR])))
    else $error("address size prefix not applied");
  a_regform_fault: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && strictReserved && !hasMemOperand
    && pfxSeen_reg[PB_ADDR] |=> invalidOpcodeFault)
    else $error("reserved address prefix did not fault");
  a_seg_ovr: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && hasMemOperand && segSeen_reg
    |=> effSegment == $past(segOvr_reg))
    else $error("segment override ignored");
  a_seg_default: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && hasMemOperand && !segSeen_reg
    |=> effSegment == $past(segSelIn))
    else $error("default segment not used");
  a_reserved_ok: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && instrSupported && !fpuEmulationBit && !fpuPending
    && !strictReserved && !hasMemOperand && !pfxSeen_reg[PB_LOCK]
    |=> instrDone)
    else $error("reserved prefix stopped the instruction");
  a_lock_fault: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && pfxSeen_reg[PB_LOCK] |=> invalidOpcodeFault
    && !instrDone)
    else $error("lock prefix executed");
  a_strict_fault: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    instrValid && strictReserved
    && (pfxSeen_reg[PB_OPSZ] || pfxSeen_reg[PB_REP]) |=> invalidOpcodeFault)
    else $error("reserved prefix did not fault in strict mode");

endmodule : simd_fpu_alias_ctl

// File: bench/tb.sv
// Self-checking testbench for the multimedia alias and prefix control block
`timescale 1ns/10ps
module tb;
  import simd_ctl_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0, isEmptyInstr = 1'b0, instrSupported = 1'b1;
  logic hasMemOperand = 1'b0, writesReg = 1'b0, pfxValid = 1'b0;
  logic fpuEmulationBit = 1'b0, strictReserved = 1'b0, fpuPending = 1'b0;
  logic handlerReturn = 1'b0, addrSizeIn = 1'b0;
  logic [2:0] destReg = 3'h0, srcReg = 3'h0, memFault = 3'h0;
  logic [63:0] resultData = 64'h0;
  logic [7:0] pfxByte = 8'h00;
  logic [1:0] segSelIn = 2'h1, segOvr = 2'h2;
  logic [15:0] tagWord;
  logic [2:0] stackTopField;
  logic [REG_W-1:0] regRead;
  logic instrDone, faultValid, invalidOpcodeFault, floatErrorOut;
  logic effAddrSize, irq;
  logic [7:0] faultVector;
  logic [1:0] effSegment;
  int n_mismatch = 0;
  int checks = 0;

  simd_fpu_alias_ctl u_simd_fpu_alias_ctl (.sys_clk(sys_clk), .rst_n(rst_n),
    .instrValid(instrValid), .isEmptyInstr(isEmptyInstr),
    .instrSupported(instrSupported), .hasMemOperand(hasMemOperand),
    .writesReg(writesReg), .destReg(destReg), .resultData(resultData),
    .srcReg(srcReg), .pfxByte(pfxByte), .pfxValid(pfxValid),
    .fpuEmulationBit(fpuEmulationBit), .strictReserved(strictReserved),
    .fpuPending(fpuPending), .handlerReturn(handlerReturn),
    .memFault(memFault), .segSelIn(segSelIn), .segOvr(segOvr),
    .addrSizeIn(addrSizeIn), .tagWord(tagWord), .stackTopField(stackTopField),
    .regRead(regRead), .instrDone(instrDone), .faultValid(faultValid),
    .faultVector(faultVector), .invalidOpcodeFault(invalidOpcodeFault),
    .floatErrorOut(floatErrorOut), .effSegment(effSegment),
    .effAddrSize(effAddrSize), .irq(irq));

  always #5 sys_clk = ~sys_clk;

  // ==================================================
  // Reporting
  task finish_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task chk(input string name, input logic [79:0] exp, input logic [79:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // ==================================================
  // One instruction, optional prefix byte in the cycle before it
  task issue(input logic mem, input logic emp, input logic supp,
             input logic [2:0] mf, input logic [7:0] pfx,
             input logic [63:0] data);
    if (pfx != 8'h00) begin
      @(posedge sys_clk);
      pfxByte <= pfx;
      pfxValid <= 1'b1;
    end
    @(posedge sys_clk);
    pfxValid <= 1'b0;
    instrValid <= 1'b1;
    isEmptyInstr <= emp;
    instrSupported <= supp;
    hasMemOperand <= mem;
    writesReg <= ~emp;
    destReg <= 3'h2;
    resultData <= data;
    memFault <= mf;
    @(posedge sys_clk);
    instrValid <= 1'b0;
    writesReg <= 1'b0;
    #1;
  endtask : issue

  task expect_fault(input logic [7:0] vec, input logic ud);
    chk("faultValid", 80'h1, {79'h0, faultValid});
    chk("faultVector", {72'h0, vec}, {72'h0, faultVector});
    chk("invalidOpcodeFault", {79'h0, ud}, {79'h0, invalidOpcodeFault});
    chk("instrDone", 80'h0, {79'h0, instrDone});
  endtask : expect_fault

  task expect_done;
    chk("instrDone", 80'h1, {79'h0, instrDone});
    chk("faultValid", 80'h0, {79'h0, faultValid});
  endtask : expect_done

  // ==================================================
  // Scenarios
  task t_write_read;
    issue(1'b0, 1'b0, 1'b1, 3'h0, 8'h00, 64'h0123456789ABCDEF);
    expect_done();
    chk("tagWord", 80'h0, {64'h0, tagWord});
    chk("stackTop", 80'h0, {77'h0, stackTopField});
    @(posedge sys_clk);
    srcReg <= 3'h2;
    @(posedge sys_clk);
    #1;
    chk("regRead", {EXP_ONES, 64'h0123456789ABCDEF}, regRead);
  endtask : t_write_read

  task t_empty_and_invalid;
    issue(1'b0, 1'b1, 1'b1, 3'h0, 8'h00, 64'h0);
    expect_done();
    chk("tagWord", 80'hFFFF, {64'h0, tagWord});
    issue(1'b0, 1'b0, 1'b0, 3'h0, 8'h00, 64'h5);
    expect_fault(VEC_INVALID_OP, 1'b1);
    chk("tagWord", 80'hFFFF, {64'h0, tagWord});
    @(posedge sys_clk);
    fpuEmulationBit <= 1'b1;
    issue(1'b0, 1'b0, 1'b1, 3'h0, 8'h00, 64'h5);
    expect_fault(VEC_INVALID_OP, 1'b1);
    @(posedge sys_clk);
    fpuEmulationBit <= 1'b0;
    issue(1'b1, 1'b0, 1'b1, 3'h0, PFX_LOCK, 64'h5);
    expect_fault(VEC_INVALID_OP, 1'b1);
  endtask : t_empty_and_invalid

  task t_mem_faults;
    logic [2:0] kinds [4];
    logic [7:0] vecs [4];
    kinds = '{3'h1, 3'h2, 3'h3, 3'h4};
    vecs = '{VEC_PAGE, VEC_SEG_NP, VEC_GP, VEC_STACK};
    for (int i = 0; i < 4; i++) begin
      issue(1'b1, 1'b0, 1'b1, kinds[i], 8'h00, 64'h7);
      expect_fault(vecs[i], 1'b0);
    end
  endtask : t_mem_faults

  task t_pending;
    @(posedge sys_clk);
    fpuPending <= 1'b1;
    issue(1'b0, 1'b0, 1'b1, 3'h0, 8'h00, 64'h9);
    expect_fault(VEC_NUMERIC, 1'b0);
    chk("floatErrorOut", 80'h1, {79'h0, floatErrorOut});
    chk("irq", 80'h1, {79'h0, irq});
    @(posedge sys_clk);
    handlerReturn <= 1'b1;
    fpuPending <= 1'b0;
    @(posedge sys_clk);
    handlerReturn <= 1'b0;
    #1;
    chk("floatErrorOut", 80'h0, {79'h0, floatErrorOut});
    issue(1'b0, 1'b0, 1'b1, 3'h0, 8'h00, 64'h9);
    expect_done();
  endtask : t_pending

  task t_prefixes;
    logic [7:0] rsv [3];
    rsv = '{PFX_OPSZ, PFX_REP, PFX_REPNE};
    issue(1'b1, 1'b0, 1'b1, 3'h0, 8'h00, 64'h1);
    chk("effSegment", 80'h1, {78'h0, effSegment});
    chk("effAddrSize", 80'h0, {79'h0, effAddrSize});
    issue(1'b1, 1'b0, 1'b1, 3'h0, PFX_FS, 64'h1);
    chk("effSegment", 80'h2, {78'h0, effSegment});
    issue(1'b1, 1'b0, 1'b1, 3'h0, PFX_ADDR, 64'h1);
    chk("effAddrSize", 80'h1, {79'h0, effAddrSize});
    for (int i = 0; i < 3; i++) begin
      issue(1'b0, 1'b0, 1'b1, 3'h0, rsv[i], 64'h1);
      expect_done();
    end
    @(posedge sys_clk);
    strictReserved <= 1'b1;
    issue(1'b0, 1'b0, 1'b1, 3'h0, PFX_OPSZ, 64'h1);
    expect_fault(VEC_INVALID_OP, 1'b1);
    issue(1'b0, 1'b0, 1'b1, 3'h0, PFX_ADDR, 64'h1);
    expect_fault(VEC_INVALID_OP, 1'b1);
    issue(1'b0, 1'b0, 1'b1, 3'h0, PFX_CS, 64'h1);
    expect_fault(VEC_INVALID_OP, 1'b1);
    issue(1'b1, 1'b0, 1'b1, 3'h0, PFX_CS, 64'h1);
    expect_done();
    chk("effSegment", 80'h2, {78'h0, effSegment});
    @(posedge sys_clk);
    strictReserved <= 1'b0;
  endtask : t_prefixes

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("tagWord", 80'hFFFF, {64'h0, tagWord});
    chk("floatErrorOut", 80'h0, {79'h0, floatErrorOut});
    t_write_read();
    t_empty_and_invalid();
    t_mem_faults();
    t_pending();
    t_prefixes();
    finish_test();
  end

  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
endmodule : tb
